//--- hdl/mvr_result_regs.sv
// Purpose: Result register bank of the motor vector engine
// Assumes: Task strobe is one cycle, synchronous to clk_in
// Notes:   Operand outputs are registered copies taken at task start
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module mvr_result_regs (
    // Clock and reset
    input  wire logic                              clk_in,
    input  wire logic                              rst_n_in,
    // Register port
    input  wire logic [mvr_pkg::ADDR_W-1:0]        reg_addr_in,
    input  wire logic [mvr_pkg::DATA_W-1:0]        reg_wdata_in,
    input  wire logic                              reg_wr_in,
    input  wire logic                              reg_rd_in,
    output logic      [mvr_pkg::DATA_W-1:0]        reg_rdata_out,
    // Engine task strobe and mode selects
    input  wire mvr_pkg::mvr_task_t                task_in,
    input  wire mvr_pkg::mvr_mode_t                mode_in,
    // Engine results
    input  wire mvr_pkg::mvr_adc_t                 adc_in,
    input  wire logic [mvr_pkg::FIELD_W-1:0]       supply_sample_in,
    input  wire mvr_pkg::mvr_dq_t                  dq_in,
    // Operands for current control
    output logic                                   ctrl_operand_valid_out,
    output mvr_pkg::mvr_dq_t                       ctrl_operand_out,
    // Operand for output phase transformation
    output logic                                   phase_operand_valid_out,
    output logic      [mvr_pkg::FIELD_W-1:0]       phase_supply_out
);
    localparam int DW = mvr_pkg::DATA_W;
    localparam int NR = mvr_pkg::NUM_REGS;

    // ======================================================================
    // Decoding helpers

    // True when the strobe names the given task
    function automatic logic task_is(
        input mvr_pkg::mvr_task_t      t,
        input logic [mvr_pkg::TASK_W-1:0] num
    );
        task_is = t.valid && (t.num == num);
    endfunction

    // True when the address selects the given register word
    function automatic logic addr_hit(
        input logic [mvr_pkg::ADDR_W-1:0] addr,
        input int                         idx
    );
        addr_hit = (addr == mvr_pkg::REG_OFS[idx]);
    endfunction

    // ======================================================================
    // Task decode
    logic in_proc;
    logic in_xform;
    logic cur_ctrl;
    logic out_xform;

    // One-cycle task qualifiers
    assign in_proc   = task_is(task_in, mvr_pkg::TASK_IN_PROC_1) ||
                       task_is(task_in, mvr_pkg::TASK_IN_PROC_2);
    assign in_xform  = task_is(task_in, mvr_pkg::TASK_IN_XFORM);
    assign cur_ctrl  = task_is(task_in, mvr_pkg::TASK_CUR_CTRL);
    assign out_xform = task_is(task_in, mvr_pkg::TASK_OUT_XFORM_1) ||
                       task_is(task_in, mvr_pkg::TASK_OUT_XFORM_2);

    // ======================================================================
    // Engine write enables and data
    logic [NR-1:0] hw_we;
    logic [DW-1:0] hw_data [NR];
    logic [NR-1:0] sw_we;
    logic [DW-1:0] reg_value [NR];

    // Phase currents, supplies and axis currents
    always_comb
    begin
        hw_we = '0;
        hw_we[mvr_pkg::IDX_PHASE_A]    = in_proc;
        hw_we[mvr_pkg::IDX_PHASE_B]    = in_proc;
        hw_we[mvr_pkg::IDX_PHASE_C]    = in_proc;
        hw_we[mvr_pkg::IDX_SUPPLY_P]   = in_proc &&
                                         mode_in.store_primary;
        hw_we[mvr_pkg::IDX_SUPPLY_S]   = in_proc &&
                                         mode_in.store_secondary;
        hw_we[mvr_pkg::IDX_DIRECT]     = in_xform;
        hw_we[mvr_pkg::IDX_QUADRATURE] = in_xform;
    end

    // Conversion left-justified with a zero nibble below it
    assign hw_data[mvr_pkg::IDX_PHASE_A] =
        DW'({adc_in.a, mvr_pkg::ADC_PAD});
    assign hw_data[mvr_pkg::IDX_PHASE_B] =
        DW'({adc_in.b, mvr_pkg::ADC_PAD});
    assign hw_data[mvr_pkg::IDX_PHASE_C] =
        DW'({adc_in.c, mvr_pkg::ADC_PAD});
    // Supply sample, limited inside the register
    assign hw_data[mvr_pkg::IDX_SUPPLY_P] = DW'(supply_sample_in);
    assign hw_data[mvr_pkg::IDX_SUPPLY_S] = DW'(supply_sample_in);
    // Axis currents kept at full signed width, scale is software's
    assign hw_data[mvr_pkg::IDX_DIRECT]     = dq_in.d;
    assign hw_data[mvr_pkg::IDX_QUADRATURE] = dq_in.q;

    // ======================================================================
    // Register storage
    genvar gi;
    generate
        for (gi = 0; gi < NR; gi++)
        begin : g_reg
            // Software write decode for this word
            assign sw_we[gi] = reg_wr_in && addr_hit(reg_addr_in, gi);

            mvr_field_reg #(
                .WIDTH (mvr_pkg::REG_WIDTH[gi]),
                .CLAMP (mvr_pkg::REG_CLAMP[gi])
            ) u_field (
                .clk_in     (clk_in),
                .rst_n_in   (rst_n_in),
                .hw_we_in   (hw_we[gi]),
                .hw_data_in (hw_data[gi]),
                .sw_we_in   (sw_we[gi]),
                .sw_data_in (reg_wdata_in),
                .value_out  (reg_value[gi])
            );
        end
    endgenerate

    // ======================================================================
    // Read path: data stands only in the cycle after the strobe
    logic [DW-1:0] rdata_reg;
    logic [DW-1:0] rdata_next;

    // Read mux, unmapped addresses return zero
    always_comb
    begin
        rdata_next = mvr_pkg::RESET_WORD;
        if (reg_rd_in)
        begin
            for (int i = 0; i < NR; i++)
            begin
                if (addr_hit(reg_addr_in, i))
                begin
                    rdata_next = reg_value[i];
                end
            end
        end
    end

    // Read data register
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rdata_reg <= mvr_pkg::RESET_WORD;
        else
            rdata_reg <= rdata_next;
    end

    assign reg_rdata_out = rdata_reg;

    // ======================================================================
    // Operand capture for engine tasks
    logic             ctrl_valid_reg;
    logic             ctrl_valid_next;
    mvr_pkg::mvr_dq_t ctrl_reg;
    mvr_pkg::mvr_dq_t ctrl_next;
    logic             phase_valid_reg;
    logic             phase_valid_next;
    logic [mvr_pkg::FIELD_W-1:0] phase_reg;
    logic [mvr_pkg::FIELD_W-1:0] phase_next;

    // Operands sampled from stored values when their task starts
    always_comb
    begin
        ctrl_valid_next  = cur_ctrl;
        ctrl_next        = ctrl_reg;
        phase_valid_next = out_xform;
        phase_next       = phase_reg;
        if (cur_ctrl)
        begin
            ctrl_next.d = reg_value[mvr_pkg::IDX_DIRECT];
            ctrl_next.q = reg_value[mvr_pkg::IDX_QUADRATURE];
        end
        if (out_xform)
        begin
            phase_next = mvr_pkg::FIELD_W'(
                reg_value[mvr_pkg::IDX_SUPPLY_P]);
        end
    end

    // Operand registers
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ctrl_valid_reg  <= 1'b0;
            ctrl_reg        <= '0;
            phase_valid_reg <= 1'b0;
            phase_reg       <= '0;
        end
        else
        begin
            ctrl_valid_reg  <= ctrl_valid_next;
            ctrl_reg        <= ctrl_next;
            phase_valid_reg <= phase_valid_next;
            phase_reg       <= phase_next;
        end
    end

    assign ctrl_operand_valid_out  = ctrl_valid_reg;
    assign ctrl_operand_out        = ctrl_reg;
    assign phase_operand_valid_out = phase_valid_reg;
    assign phase_supply_out        = phase_reg;

    // ======================================================================
    // Assertions

    AST_ADC_UPDATE: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        in_proc |=> reg_value[mvr_pkg::IDX_PHASE_A] ==
                    DW'({$past(adc_in.a), mvr_pkg::ADC_PAD}) &&
                    reg_value[mvr_pkg::IDX_PHASE_C] ==
                    DW'({$past(adc_in.c), mvr_pkg::ADC_PAD}))
        else $error("Phase result not stored at input processing");

    AST_ADC_HOLD: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (!in_proc && !sw_we[mvr_pkg::IDX_PHASE_B]) |=>
            $stable(reg_value[mvr_pkg::IDX_PHASE_B]))
        else $error("Phase result changed without a cause");

    AST_PRI_GATED: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (in_proc && !mode_in.store_primary &&
         !sw_we[mvr_pkg::IDX_SUPPLY_P]) |=>
            $stable(reg_value[mvr_pkg::IDX_SUPPLY_P]))
        else $error("Primary supply stored while not selected");

    AST_SEC_UPDATE: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (in_proc && mode_in.store_secondary &&
         DW'(supply_sample_in) <= mvr_pkg::SUPPLY_MAX) |=>
            reg_value[mvr_pkg::IDX_SUPPLY_S] ==
            DW'($past(supply_sample_in)))
        else $error("Secondary supply not stored when selected");

    AST_PHASE_OPERAND: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        out_xform |=> phase_operand_valid_out &&
            DW'(phase_supply_out) ==
            $past(reg_value[mvr_pkg::IDX_SUPPLY_P]) ##1
            $stable(phase_supply_out) || $past(out_xform))
        else $error("Supply operand wrong at output transformation");

    AST_SUPPLY_LIMIT: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        reg_value[mvr_pkg::IDX_SUPPLY_P] <= mvr_pkg::SUPPLY_MAX &&
        reg_value[mvr_pkg::IDX_SUPPLY_S] <= mvr_pkg::SUPPLY_MAX)
        else $error("Supply value above its limit");

    AST_DQ_UPDATE: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        in_xform |=> reg_value[mvr_pkg::IDX_DIRECT] == $past(dq_in.d) &&
                     reg_value[mvr_pkg::IDX_QUADRATURE] == $past(dq_in.q))
        else $error("Axis currents not stored at coordinate transform");

    AST_CTRL_OPERAND: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        cur_ctrl |=> ctrl_operand_valid_out &&
            ctrl_operand_out.d == $past(reg_value[mvr_pkg::IDX_DIRECT]) &&
            ctrl_operand_out.q ==
            $past(reg_value[mvr_pkg::IDX_QUADRATURE]))
        else $error("Axis operands wrong at current control");

    AST_UPPER_ZERO: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (reg_rd_in && reg_addr_in <= mvr_pkg::OFS_SUPPLY_S) |=>
            reg_rdata_out[mvr_pkg::DATA_W-1:mvr_pkg::FIELD_W] == '0)
        else $error("Upper half of a 16-bit register read non-zero");

    AST_READ_WINDOW: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        !reg_rd_in |=> reg_rdata_out == 32'h0000_0000)
        else $error("Read data present without a read");

    AST_SW_KEEP: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (sw_we[mvr_pkg::IDX_PHASE_A] && !in_proc) |=>
            reg_value[mvr_pkg::IDX_PHASE_A] ==
            DW'($past(reg_wdata_in[15:0])))
        else $error("Software value not kept in low bits");

    AST_PHASE_B_UPDATE: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        in_proc |=> reg_value[mvr_pkg::IDX_PHASE_B] ==
                    DW'({$past(adc_in.b), mvr_pkg::ADC_PAD}))
        else $error("Phase b result not left-justified");

    AST_PRI_UPDATE: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (in_proc && mode_in.store_primary &&
         DW'(supply_sample_in) <= mvr_pkg::SUPPLY_MAX) |=>
            reg_value[mvr_pkg::IDX_SUPPLY_P] ==
            DW'($past(supply_sample_in)))
        else $error("Primary supply not stored when selected");

    AST_SEC_GATED: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (in_proc && !mode_in.store_secondary &&
         !sw_we[mvr_pkg::IDX_SUPPLY_S]) |=>
            $stable(reg_value[mvr_pkg::IDX_SUPPLY_S]))
        else $error("Secondary supply stored while not selected");

    AST_DQ_HOLD: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (!in_xform && !sw_we[mvr_pkg::IDX_QUADRATURE]) |=>
            $stable(reg_value[mvr_pkg::IDX_QUADRATURE]))
        else $error("Axis current changed without a cause");

    AST_CTRL_PULSE: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        !cur_ctrl |=> !ctrl_operand_valid_out)
        else $error("Current control operand valid without task");

    // ======================================================================
    // Cover points

    COV_BOTH_SUPPLIES: cover property (
        @(posedge clk_in) disable iff (!rst_n_in)
        in_proc && mode_in.store_primary && mode_in.store_secondary);

    COV_DQ_THEN_CTRL: cover property (
        @(posedge clk_in) disable iff (!rst_n_in)
        in_xform ##[1:20] cur_ctrl);

    COV_SW_HW_CLASH: cover property (
        @(posedge clk_in) disable iff (!rst_n_in)
        in_proc && sw_we[mvr_pkg::IDX_PHASE_B]);

    COV_SUPPLY_CLAMP: cover property (
        @(posedge clk_in) disable iff (!rst_n_in)
        hw_we[mvr_pkg::IDX_SUPPLY_S] &&
        DW'(supply_sample_in) > mvr_pkg::SUPPLY_MAX);

    COV_SW_CLAMP: cover property (
        @(posedge clk_in) disable iff (!rst_n_in)
        sw_we[mvr_pkg::IDX_SUPPLY_P] &&
        DW'(reg_wdata_in[mvr_pkg::FIELD_W-1:0]) > mvr_pkg::SUPPLY_MAX);

endmodule

//--- inc/mvr_pkg.sv
// Purpose: Constants and carrier types of the vector engine result bank
// Assumes: Byte addresses on a 32-bit register port, one word per register
// Notes:   Offsets of the register words are local to this bank
package mvr_pkg;

    // ======================================================================
    // Widths
    localparam int DATA_W   = 32;
    localparam int ADDR_W   = 5;
    localparam int TASK_W   = 4;
    localparam int ADC_W    = 12;
    localparam int FIELD_W  = 16;
    localparam int PAD_W    = 4;
    localparam int NUM_REGS = 7;

    // ======================================================================
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_PHASE_A   = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_PHASE_B   = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_PHASE_C   = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_SUPPLY_P  = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_SUPPLY_S  = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_DIRECT    = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_QUADRATURE = 5'h18;

    // Register index order used by the bank
    localparam int IDX_PHASE_A    = 0;
    localparam int IDX_PHASE_B    = 1;
    localparam int IDX_PHASE_C    = 2;
    localparam int IDX_SUPPLY_P   = 3;
    localparam int IDX_SUPPLY_S   = 4;
    localparam int IDX_DIRECT     = 5;
    localparam int IDX_QUADRATURE = 6;

    localparam logic [ADDR_W-1:0] REG_OFS [NUM_REGS] = '{
        OFS_PHASE_A, OFS_PHASE_B, OFS_PHASE_C, OFS_SUPPLY_P,
        OFS_SUPPLY_S, OFS_DIRECT, OFS_QUADRATURE};
    localparam int REG_WIDTH [NUM_REGS] = '{
        FIELD_W, FIELD_W, FIELD_W, FIELD_W, FIELD_W, DATA_W, DATA_W};
    localparam bit REG_CLAMP [NUM_REGS] = '{
        1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

    // ======================================================================
    // Reset and limit values
    localparam logic [DATA_W-1:0] RESET_WORD  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] SUPPLY_MAX  = 32'h0000_7fff;
    localparam logic [PAD_W-1:0]  ADC_PAD     = 4'h0;

    // ======================================================================
    // Engine task numbers
    localparam logic [TASK_W-1:0] TASK_IN_PROC_1  = 4'h2;
    localparam logic [TASK_W-1:0] TASK_IN_PROC_2  = 4'ha;
    localparam logic [TASK_W-1:0] TASK_IN_XFORM   = 4'h4;
    localparam logic [TASK_W-1:0] TASK_CUR_CTRL   = 4'h5;
    localparam logic [TASK_W-1:0] TASK_OUT_XFORM_1 = 4'h8;
    localparam logic [TASK_W-1:0] TASK_OUT_XFORM_2 = 4'hb;

    // ======================================================================
    // Carriers
    typedef struct packed {
        logic              valid;
        logic [TASK_W-1:0] num;
    } mvr_task_t;

    typedef struct packed {
        logic [ADC_W-1:0] a;
        logic [ADC_W-1:0] b;
        logic [ADC_W-1:0] c;
    } mvr_adc_t;

    typedef struct packed {
        logic store_primary;
        logic store_secondary;
    } mvr_mode_t;

    typedef struct packed {
        logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] q;
    } mvr_dq_t;

endpackage

//--- hdl/mvr_field_reg.sv
// Purpose: One result register with engine and software write ports
// Assumes: Engine write and software write may come in the same cycle
// Notes:   Engine write wins; value is zero-extended to a bus word
`timescale 1ns/1ps
module mvr_field_reg #(
    parameter int WIDTH = 32,
    parameter bit CLAMP = 1'b0
) (
    // Clock and reset
    input  wire logic                       clk_in,
    input  wire logic                       rst_n_in,
    // Engine port
    input  wire logic                       hw_we_in,
    input  wire logic [mvr_pkg::DATA_W-1:0] hw_data_in,
    // Software port
    input  wire logic                       sw_we_in,
    input  wire logic [mvr_pkg::DATA_W-1:0] sw_data_in,
    // Stored value
    output logic      [mvr_pkg::DATA_W-1:0] value_out
);
    localparam int DW = mvr_pkg::DATA_W;

    logic [WIDTH-1:0] value_reg;
    logic [WIDTH-1:0] value_next;
    logic [DW-1:0]    word;
    logic [WIDTH-1:0] field;

    // ======================================================================
    // Next value: engine over software, upper word bits dropped
    always_comb
    begin
        word       = hw_we_in ? hw_data_in : sw_data_in;
        field      = WIDTH'(word);
        value_next = value_reg;
        if (CLAMP && (DW'(field) > mvr_pkg::SUPPLY_MAX))
        begin
            field = WIDTH'(mvr_pkg::SUPPLY_MAX);
        end
        if (hw_we_in || sw_we_in)
        begin
            value_next = field;
        end
    end

    // State register
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            value_reg <= WIDTH'(mvr_pkg::RESET_WORD);
        else
            value_reg <= value_next;
    end

    // Zero-extended view, bits above WIDTH read as zero
    assign value_out = DW'(value_reg);

endmodule

//--- verif/mvr_result_regs_test.sv
// Purpose: Self-checking bench for the vector engine result bank
// Assumes: Offsets, task numbers and limits as declared in mvr_pkg
// Notes:   Strobes by non-blocking assignment at the rising edge, engine data by non-blocking assignment 1 ns after one
`timescale 1ns/1ps
module mvr_result_regs_test;

    // ======================================================================
    // Clock, reset and design signals
    logic                           clk_in;
    logic                           rst_n_in;
    logic [mvr_pkg::ADDR_W-1:0]     reg_addr_in;
    logic [mvr_pkg::DATA_W-1:0]     reg_wdata_in;
    logic                           reg_wr_in;
    logic                           reg_rd_in;
    logic [mvr_pkg::DATA_W-1:0]     reg_rdata_out;
    mvr_pkg::mvr_task_t             task_in;
    mvr_pkg::mvr_mode_t             mode_in;
    mvr_pkg::mvr_adc_t              adc_in;
    logic [mvr_pkg::FIELD_W-1:0]    supply_sample_in;
    mvr_pkg::mvr_dq_t               dq_in;
    logic                           ctrl_operand_valid_out;
    mvr_pkg::mvr_dq_t               ctrl_operand_out;
    logic                           phase_operand_valid_out;
    logic [mvr_pkg::FIELD_W-1:0]    phase_supply_out;
    int                             n_mismatch;
    int                             checks;

    // Design under test
    mvr_result_regs i_dut (
        .clk_in                  (clk_in),
        .rst_n_in                (rst_n_in),
        .reg_addr_in             (reg_addr_in),
        .reg_wdata_in            (reg_wdata_in),
        .reg_wr_in               (reg_wr_in),
        .reg_rd_in               (reg_rd_in),
        .reg_rdata_out           (reg_rdata_out),
        .task_in                 (task_in),
        .mode_in                 (mode_in),
        .adc_in                  (adc_in),
        .supply_sample_in        (supply_sample_in),
        .dq_in                   (dq_in),
        .ctrl_operand_valid_out  (ctrl_operand_valid_out),
        .ctrl_operand_out        (ctrl_operand_out),
        .phase_operand_valid_out (phase_operand_valid_out),
        .phase_supply_out        (phase_supply_out)
    );

    // 200 MHz clock
    always #2.5 clk_in = ~clk_in;

    // ======================================================================
    // Shared tasks
    task automatic complete_run;
        $display("Checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Compare one word
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One-cycle software write
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge clk_in);
        reg_wr_in    <= 1'b0;
    endtask

    // Read, compare the answer, then check the data falls back to zero
    task automatic rd(input string what, input logic [4:0] a,
                      input logic [31:0] exp);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge clk_in);
        reg_rd_in   <= 1'b0;
        #1 chk(what, exp, reg_rdata_out);
        @(posedge clk_in);
        #1 chk("rdata idle", 32'h0, reg_rdata_out);
    endtask

    // One-cycle engine task strobe; caller samples after the taking edge
    task automatic fire(input logic [3:0] n);
        @(posedge clk_in);
        task_in <= '{valid: 1'b1, num: n};
        @(posedge clk_in);
        task_in.valid <= 1'b0;
        #1;
    endtask

    // ======================================================================
    // Scenarios
    task automatic t_reset;
        for (int i = 0; i < mvr_pkg::NUM_REGS; i++)
            rd("reset value", mvr_pkg::REG_OFS[i], 32'h0);
        rd("unaligned", 5'h02, 32'h0);
        rd("unmapped", 5'h1c, 32'h0);
    endtask

    task automatic t_phase;
        adc_in <= '{a: 12'habc, b: 12'h123, c: 12'hfff};
        fire(mvr_pkg::TASK_IN_PROC_1);
        rd("phase a", mvr_pkg::OFS_PHASE_A, 32'h0000_abc0);
        rd("phase b", mvr_pkg::OFS_PHASE_B, 32'h0000_1230);
        rd("phase c", mvr_pkg::OFS_PHASE_C, 32'h0000_fff0);
        adc_in <= '{a: 12'h001, b: 12'h800, c: 12'h7ff};
        fire(mvr_pkg::TASK_IN_PROC_2);
        rd("phase a", mvr_pkg::OFS_PHASE_A, 32'h0000_0010);
        rd("phase c", mvr_pkg::OFS_PHASE_C, 32'h0000_7ff0);
        adc_in <= '{a: 12'h555, b: 12'h555, c: 12'h555};
        for (int n = 0; n < 16; n++)
            if (n != 2 && n != 10)
                fire(4'(n));
        rd("phase a other", mvr_pkg::OFS_PHASE_A, 32'h0000_0010);
        wr(mvr_pkg::OFS_PHASE_A, 32'hffff_5a5f);
        rd("phase a sw", mvr_pkg::OFS_PHASE_A, 32'h0000_5a5f);
        // Engine and software hit phase b in the same cycle
        @(posedge clk_in);
        reg_addr_in  <= mvr_pkg::OFS_PHASE_B;
        reg_wdata_in <= 32'h0000_1111;
        reg_wr_in    <= 1'b1;
        task_in      <= '{valid: 1'b1, num: mvr_pkg::TASK_IN_PROC_1};
        @(posedge clk_in);
        reg_wr_in     <= 1'b0;
        task_in.valid <= 1'b0;
        rd("phase b clash", mvr_pkg::OFS_PHASE_B, 32'h0000_5550);
    endtask

    task automatic t_supply;
        mode_in <= '{store_primary: 1'b1, store_secondary: 1'b1};
        supply_sample_in <= 16'h1234;
        fire(mvr_pkg::TASK_IN_PROC_1);
        rd("primary", mvr_pkg::OFS_SUPPLY_P, 32'h0000_1234);
        rd("secondary", mvr_pkg::OFS_SUPPLY_S, 32'h0000_1234);
        mode_in <= '{store_primary: 1'b0, store_secondary: 1'b1};
        supply_sample_in <= 16'hffff;
        fire(mvr_pkg::TASK_IN_PROC_2);
        rd("primary", mvr_pkg::OFS_SUPPLY_P, 32'h0000_1234);
        rd("secondary", mvr_pkg::OFS_SUPPLY_S, 32'h0000_7fff);
        mode_in <= '{store_primary: 1'b1, store_secondary: 1'b0};
        supply_sample_in <= 16'h0555;
        fire(mvr_pkg::TASK_IN_PROC_1);
        rd("primary on", mvr_pkg::OFS_SUPPLY_P, 32'h0000_0555);
        rd("second off", mvr_pkg::OFS_SUPPLY_S, 32'h0000_7fff);
        wr(mvr_pkg::OFS_SUPPLY_P, 32'h0000_9000);
        rd("primary sw", mvr_pkg::OFS_SUPPLY_P, 32'h0000_7fff);
        wr(mvr_pkg::OFS_SUPPLY_S, 32'habcd_0123);
        rd("second sw", mvr_pkg::OFS_SUPPLY_S, 32'h0000_0123);
    endtask

    task automatic t_axis;
        dq_in <= '{d: 32'h8000_0000, q: 32'h7fff_ffff};
        fire(mvr_pkg::TASK_IN_XFORM);
        fire(mvr_pkg::TASK_CUR_CTRL);
        chk("ctrl valid", 32'h1, 32'(ctrl_operand_valid_out));
        chk("ctrl d", 32'h8000_0000, ctrl_operand_out.d);
        chk("ctrl q", 32'h7fff_ffff, ctrl_operand_out.q);
        chk("phase valid", 32'h0, 32'(phase_operand_valid_out));
        @(posedge clk_in);
        #1 chk("ctrl valid end", 32'h0, 32'(ctrl_operand_valid_out));
        rd("direct", mvr_pkg::OFS_DIRECT, 32'h8000_0000);
        rd("quadrature", mvr_pkg::OFS_QUADRATURE, 32'h7fff_ffff);
        dq_in <= '{d: 32'h1111_1111, q: 32'h2222_2222};
        fire(mvr_pkg::TASK_IN_PROC_1);
        rd("direct other", mvr_pkg::OFS_DIRECT, 32'h8000_0000);
        wr(mvr_pkg::OFS_DIRECT, 32'h1357_9bdf);
        fire(mvr_pkg::TASK_CUR_CTRL);
        chk("ctrl d sw", 32'h1357_9bdf, ctrl_operand_out.d);
        chk("ctrl q sw", 32'h7fff_ffff, ctrl_operand_out.q);
    endtask

    task automatic t_phase_op;
        wr(mvr_pkg::OFS_SUPPLY_P, 32'h0000_2468);
        fire(mvr_pkg::TASK_OUT_XFORM_1);
        chk("phase valid", 32'h1, 32'(phase_operand_valid_out));
        chk("phase supply", 32'h0000_2468, 32'(phase_supply_out));
        chk("ctrl valid", 32'h0, 32'(ctrl_operand_valid_out));
        wr(mvr_pkg::OFS_SUPPLY_P, 32'h0000_0101);
        fire(mvr_pkg::TASK_OUT_XFORM_2);
        chk("phase supply", 32'h0000_0101, 32'(phase_supply_out));
        @(posedge clk_in);
        #1 chk("phase valid end", 32'h0, 32'(phase_operand_valid_out));
    endtask

    // Reset in mid-run clears the stored values
    task automatic t_rereset;
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd("direct reset", mvr_pkg::OFS_DIRECT, 32'h0);
        rd("primary reset", mvr_pkg::OFS_SUPPLY_P, 32'h0);
    endtask

    // ======================================================================
    // Main sequence
    initial
    begin
        clk_in = 1'b0;
        rst_n_in = 1'b0;
        reg_addr_in = '0;
        reg_wdata_in = '0;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        task_in = '0;
        mode_in = '0;
        adc_in = '0;
        supply_sample_in = '0;
        dq_in = '0;
        n_mismatch = 0;
        checks = 0;
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_reset();
        t_phase();
        t_supply();
        t_axis();
        t_phase_op();
        t_rereset();
        complete_run();
    end

    // Guard against a hang
    initial
    begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        complete_run();
    end

endmodule
